//--- pkg/pom_defines.svh
`ifndef POM_DEFINES_SVH
`define POM_DEFINES_SVH
// Notes on behaviour
// - Pulse one source in bits 2..0 picks one of five summed power quantities.
// - Reserved pulse one source codes 101, 110, 111 generate no pulse one signal.
// - Pulse two source in bits 5..3, reset 001, same five quantity codes.
// - Reserved pulse two source codes generate no pulse two signal.
// - Pulse three source in bits 8..6, reset 010, same five quantity codes.
// - Reserved pulse three source codes generate no pulse three signal.
// - Bit 9, reset 1, disables pin one; its converter keeps running.
// - Bit 10, reset 1, disables pin two; its converter keeps running.
// - Bit 11, reset 1, disables pin three; its converter keeps running.
// - Bit 12 set captures pulse one energy registers on each pulse one.
// - Bit 13 set captures pulse two energy registers on each pulse two.
// - Bit 14 set captures pulse three energy registers; capture bits reset 0.
// - Bit 15 resets to zero and affects nothing.
// - Each output sums only phases whose inclusion bit is set in its group.

// ----------------------------------------
// Register map
// ----------------------------------------
`define POM_MODE_ADDR      32'h0000_e610
`define POM_INCLUDE_ADDR   32'h0000_e620
`define POM_STATUS_ADDR    32'h0000_e624
`define POM_COUNT_ADDR     32'h0000_e628

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define POM_MODE_RESET     16'h0e88
`define POM_MODE_WMASK     16'h7fff
`define POM_INCLUDE_RESET  16'h01ff
`define POM_INCLUDE_WMASK  16'h01ff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POM_ST_ACTIVE_LSB  0
`define POM_ST_SIGN_LSB    4
`define POM_ST_RUN_LSB     8

// ----------------------------------------
// Timing
// ----------------------------------------
`define POM_CLK_PERIOD_NS  4
`define POM_PULSE_WIDTH_NS 1000
`define POM_PULSE_CYCLES   ((`POM_PULSE_WIDTH_NS + `POM_CLK_PERIOD_NS - 1) / `POM_CLK_PERIOD_NS)
`define POM_DFC_THRESHOLD  32'h0001_0000
`endif

//--- pkg/pom_pkg.sv
package pom_pkg;
    typedef enum logic [2:0] {
        POM_SRC_TOTAL_ACTIVE   = 3'h0,
        POM_SRC_TOTAL_REACTIVE = 3'h1,
        POM_SRC_APPARENT       = 3'h2,
        POM_SRC_FUND_ACTIVE    = 3'h3,
        POM_SRC_FUND_REACTIVE  = 3'h4
    } pom_source_type;

    typedef enum logic [1:0] {
        POM_BUS_IDLE = 2'b01,
        POM_BUS_DATA = 2'b10
    } pom_bus_state_type;

    typedef struct packed {
        logic       reserved_bit;
        logic       pulse3_energy_capture;
        logic       pulse2_energy_capture;
        logic       pulse1_energy_capture;
        logic       pulse3_pin_disable;
        logic       pulse2_pin_disable;
        logic       pulse1_pin_disable;
        logic [2:0] pulse3_source_select;
        logic [2:0] pulse2_source_select;
        logic [2:0] pulse1_source_select;
    } pom_mode_type;

    typedef struct packed {
        logic [6:0] reserved_bits;
        logic [2:0] pulse3_phase_include;
        logic [2:0] pulse2_phase_include;
        logic [2:0] pulse1_phase_include;
    } pom_include_type;

    typedef struct packed {
        logic [2:0][15:0] total_active;
        logic [2:0][15:0] total_reactive;
        logic [2:0][15:0] apparent;
        logic [2:0][15:0] fund_active;
        logic [2:0][15:0] fund_reactive;
    } pom_phase_power_type;

    typedef struct packed {
        logic [31:0] addr;
        logic        write;
        logic [3:0]  lanes;
    } pom_bus_req_type;
endpackage

//--- src/pom_freq_converter.sv
`timescale 1ns/1ns
`include "pom_defines.svh"

module pom_freq_converter (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        run,
    input  wire logic [17:0] magnitude,
    output logic             pulse,
    output logic             active
);
    localparam logic [7:0] WIDTH = 8'(`POM_PULSE_CYCLES);

    logic [31:0] accum;
    logic [31:0] next_accum;
    logic [7:0]  width_count;

    assign next_accum = accum + {14'h0000, magnitude};

    // ----------------------------------------
    // Accumulate and emit pulses
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accum <= 32'h0000_0000;
            pulse <= 1'b0;
        end else if (!run) begin
            accum <= 32'h0000_0000;
            pulse <= 1'b0;
        end else if (next_accum >= `POM_DFC_THRESHOLD) begin
            accum <= next_accum - `POM_DFC_THRESHOLD;
            pulse <= 1'b1;
        end else begin
            accum <= next_accum;
            pulse <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pulse width stretch
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            width_count <= 8'h00;
            active      <= 1'b0;
        end else if (pulse) begin
            width_count <= WIDTH - 8'h01;
            active      <= 1'b1;
        end else if (width_count != 8'h00) begin
            width_count <= width_count - 8'h01;
        end else begin
            active <= 1'b0;
        end
    end
endmodule

//--- src/pom_pulse_output_mode.sv
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "pom_defines.svh"

module pom_pulse_output_mode (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    input  wire pom_pkg::pom_phase_power_type phase_power,
    output logic                              pulse_output_one,
    output logic                              pulse_output_two,
    output logic                              pulse_output_three,
    output logic [2:0]                        energy_capture_strobe
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic [3:0] lane_mask(
        input logic [2:0] size,
        input logic [1:0] low
    );
        logic [3:0] m;
        m = 4'h0;
        case (size)
            3'h0: m = 4'h1 << low;
            3'h1: m = low[1] ? 4'hc : 4'h3;
            default: m = 4'hf;
        endcase
        return m;
    endfunction

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  lanes,
        input logic [15:0] wmask
    );
        logic [15:0] v;
        v = old;
        if (lanes[0]) begin
            v[7:0] = data[7:0];
        end
        if (lanes[1]) begin
            v[15:8] = data[15:8];
        end
        return (v & wmask) | (old & ~wmask);
    endfunction

    function automatic logic [2:0][15:0] pick_quantity(
        input pom_pkg::pom_phase_power_type pw,
        input logic [2:0]                   src
    );
        logic [2:0][15:0] q;
        q = '0;
        case (src)
            pom_pkg::POM_SRC_TOTAL_ACTIVE:   q = pw.total_active;
            pom_pkg::POM_SRC_TOTAL_REACTIVE: q = pw.total_reactive;
            pom_pkg::POM_SRC_APPARENT:       q = pw.apparent;
            pom_pkg::POM_SRC_FUND_ACTIVE:    q = pw.fund_active;
            pom_pkg::POM_SRC_FUND_REACTIVE:  q = pw.fund_reactive;
            default:                         q = '0;
        endcase
        return q;
    endfunction

    function automatic logic [17:0] phase_sum(
        input logic [2:0][15:0] q,
        input logic [2:0]       phase_incl
    );
        logic [17:0] s;
        s = 18'h00000;
        for (int p = 0; p < 3; p++) begin
            if (phase_incl[p]) begin
                s = s + {{2{q[p][15]}}, q[p]};
            end
        end
        return s;
    endfunction

    function automatic logic source_valid(input logic [2:0] src);
        return src <= 3'(pom_pkg::POM_SRC_FUND_REACTIVE);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    pom_pkg::pom_mode_type      mode;
    pom_pkg::pom_mode_type      next_mode;
    pom_pkg::pom_include_type   phase_incl;
    pom_pkg::pom_include_type   next_include;
    pom_pkg::pom_bus_state_type bus_state;
    pom_pkg::pom_bus_req_type   pending;
    logic                       addr_take;
    logic                       write_now;
    logic [2:0][2:0]            src_sel;
    logic [2:0][2:0]            inc_sel;
    logic [2:0]                 pin_disable;
    logic [2:0]                 capture_en;
    logic [2:0]                 run;
    logic [2:0][17:0]           sum;
    logic [2:0][17:0]           magnitude;
    logic [2:0]                 dfc_pulse;
    logic [2:0]                 dfc_active;
    logic [2:0]                 sum_sign;
    logic [2:0][7:0]            pulse_count;
    logic [31:0]                status_word;
    logic [31:0]                count_word;
    logic [31:0]                read_value;
    logic                       count_clear;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_take = hsel && htrans[1] && hready;
    assign write_now = (bus_state == pom_pkg::POM_BUS_DATA) && pending.write;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_state <= pom_pkg::POM_BUS_IDLE;
        end else begin
            case (bus_state)
                pom_pkg::POM_BUS_IDLE: begin
                    if (addr_take) begin
                        bus_state <= pom_pkg::POM_BUS_DATA;
                    end
                end
                pom_pkg::POM_BUS_DATA: begin
                    if (!addr_take) begin
                        bus_state <= pom_pkg::POM_BUS_IDLE;
                    end
                end
                default: bus_state <= pom_pkg::POM_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pending <= '0;
        end else if (addr_take) begin
            pending.addr  <= {haddr[31:2], 2'b00};
            pending.write <= hwrite;
            pending.lanes <= lane_mask(hsize, haddr[1:0]);
        end else begin
            pending.write <= 1'b0;
        end
    end

    // ----------------------------------------
    // Register write path
    // ----------------------------------------
    always_comb begin
        next_mode    = mode;
        next_include = phase_incl;
        count_clear  = 1'b0;
        if (write_now) begin
            case (pending.addr)
                `POM_MODE_ADDR: begin
                    next_mode = merge16(mode, hwdata, pending.lanes,
                                        `POM_MODE_WMASK);
                end
                `POM_INCLUDE_ADDR: begin
                    next_include = merge16(phase_incl, hwdata, pending.lanes,
                                           `POM_INCLUDE_WMASK);
                end
                `POM_COUNT_ADDR: begin
                    count_clear = 1'b1;
                end
                default: begin
                    next_mode = mode;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode <= `POM_MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_incl <= `POM_INCLUDE_RESET;
        end else begin
            phase_incl <= next_include;
        end
    end

    // ----------------------------------------
    // Register read path
    // ----------------------------------------
    assign status_word = {21'h000000, run, 1'b0, sum_sign, 1'b0, dfc_active};
    assign count_word  = {8'h00, pulse_count[2], pulse_count[1], pulse_count[0]};

    always_comb begin
        case ({haddr[31:2], 2'b00})
            `POM_MODE_ADDR:    read_value = {16'h0000, next_mode};
            `POM_INCLUDE_ADDR: read_value = {16'h0000, next_include};
            `POM_STATUS_ADDR:  read_value = status_word;
            `POM_COUNT_ADDR:   read_value = count_word;
            default:           read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= read_value;
        end
    end

    // ----------------------------------------
    // Field unpacking
    // ----------------------------------------
    assign src_sel[0]  = mode.pulse1_source_select;
    assign src_sel[1]  = mode.pulse2_source_select;
    assign src_sel[2]  = mode.pulse3_source_select;
    assign inc_sel[0]  = phase_incl.pulse1_phase_include;
    assign inc_sel[1]  = phase_incl.pulse2_phase_include;
    assign inc_sel[2]  = phase_incl.pulse3_phase_include;
    assign pin_disable = {mode.pulse3_pin_disable,
                          mode.pulse2_pin_disable,
                          mode.pulse1_pin_disable};
    assign capture_en  = {mode.pulse3_energy_capture,
                          mode.pulse2_energy_capture,
                          mode.pulse1_energy_capture};

    // ----------------------------------------
    // Quantity select, phase sums, converters
    // ----------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_out
        assign run[i]       = source_valid(src_sel[i]);
        assign sum[i]       = phase_sum(pick_quantity(phase_power, src_sel[i]),
                                        inc_sel[i]);
        assign sum_sign[i]  = sum[i][17];
        assign magnitude[i] = sum[i][17] ? 18'(-sum[i]) : sum[i];

        pom_freq_converter u_dfc (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .run       (run[i]),
            .magnitude (magnitude[i]),
            .pulse     (dfc_pulse[i]),
            .active    (dfc_active[i])
        );
    end

    // ----------------------------------------
    // Output pins, active low, idle high
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_output_one <= 1'b1;
        end else begin
            pulse_output_one <= pin_disable[0] | ~dfc_active[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_output_two <= 1'b1;
        end else begin
            pulse_output_two <= pin_disable[1] | ~dfc_active[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_output_three <= 1'b1;
        end else begin
            pulse_output_three <= pin_disable[2] | ~dfc_active[2];
        end
    end

    // ----------------------------------------
    // Energy capture strobes
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            energy_capture_strobe <= 3'h0;
        end else begin
            energy_capture_strobe <= dfc_pulse & capture_en;
        end
    end

    // ----------------------------------------
    // Pulse counters, clear with a same-cycle pulse loads one
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_count <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (dfc_pulse[i]) begin
                    pulse_count[i] <= count_clear ? 8'h01 : pulse_count[i] + 8'h01;
                end else if (count_clear) begin
                    pulse_count[i] <= 8'h00;
                end
            end
        end
    end
endmodule

//--- test/pom_mode_chk.sv
`timescale 1ns/1ns
module pom_mode_chk (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        pulse_output_one,
    input wire logic        pulse_output_two,
    input wire logic        pulse_output_three,
    input wire logic [2:0]  energy_capture_strobe
);
    logic        wr_pend;
    logic [15:0] mode_sh;

    // ----------------------------------------
    // Mode shadow
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            mode_sh <= 16'h0e88;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite && (haddr == 32'h0000_e610);
            if (wr_pend) begin
                mode_sh <= hwdata[15:0] & 16'h7fff;
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_hold4(logic b);
        b [*4];
    endsequence

    property p_idle; $fell(sys_rst) |-> pulse_output_one && pulse_output_two
        && pulse_output_three && energy_capture_strobe == 3'h0; endproperty
    property p_dis1; s_hold4(mode_sh[9]) |-> pulse_output_one; endproperty
    property p_dis2; s_hold4(mode_sh[10]) |-> pulse_output_two; endproperty
    property p_dis3; s_hold4(mode_sh[11]) |-> pulse_output_three; endproperty
    property p_cap1; s_hold4(!mode_sh[12]) |-> !energy_capture_strobe[0]; endproperty
    property p_cap2; s_hold4(!mode_sh[13]) |-> !energy_capture_strobe[1]; endproperty
    property p_cap3; s_hold4(!mode_sh[14]) |-> !energy_capture_strobe[2]; endproperty
    property p_rsv1; s_hold4(mode_sh[2:0] > 3'h4) |-> !energy_capture_strobe[0]; endproperty
    property p_rsv2; s_hold4(mode_sh[5:3] > 3'h4) |-> !energy_capture_strobe[1]; endproperty
    property p_rsv3; s_hold4(mode_sh[8:6] > 3'h4) |-> !energy_capture_strobe[2]; endproperty

    a_idle: assert property (p_idle) else $error("outputs not idle after reset");
    a_dis1: assert property (p_dis1) else $error("pin one low while disabled");
    a_dis2: assert property (p_dis2) else $error("pin two low while disabled");
    a_dis3: assert property (p_dis3) else $error("pin three low while disabled");
    a_cap1: assert property (p_cap1) else $error("capture one without enable");
    a_cap2: assert property (p_cap2) else $error("capture two without enable");
    a_cap3: assert property (p_cap3) else $error("capture three without enable");
    a_rsv1: assert property (p_rsv1) else $error("pulse one on reserved code");
    a_rsv2: assert property (p_rsv2) else $error("pulse two on reserved code");
    a_rsv3: assert property (p_rsv3) else $error("pulse three on reserved code");
endmodule

bind pom_pulse_output_mode pom_mode_chk u_pom_mode_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .pulse_output_one(pulse_output_one), .pulse_output_two(pulse_output_two),
    .pulse_output_three(pulse_output_three), .energy_capture_strobe(energy_capture_strobe)
);

//--- test/pom_led_model.sv
`timescale 1ns/1ns
module pom_led_model (
    input wire logic pin_n,
    output int       flashes
);
    // ----------------------------------------
    // Counts each lighting of the LED
    // ----------------------------------------
    initial flashes = 0;
    always @(negedge pin_n) begin
        flashes++;
    end
endmodule

//--- test/pom_pulse_output_mode_bench.sv
`timescale 1ns/1ns
`include "pom_defines.svh"
module pom_pulse_output_mode_bench;
    logic                         ref_clk;
    logic                         sys_rst;
    logic                         hsel;
    logic [31:0]                  haddr;
    logic [1:0]                   htrans;
    logic                         hwrite;
    logic [2:0]                   hsize;
    logic [31:0]                  hwdata;
    logic                         hreadyout;
    logic                         hresp;
    logic [31:0]                  hrdata;
    pom_pkg::pom_phase_power_type phase_power;
    logic                         pulse_output_one;
    logic                         pulse_output_two;
    logic                         pulse_output_three;
    logic [2:0]                   energy_capture_strobe;
    int                           fl[3];
    int                           cnt[3];
    int                           err_total;
    int                           checks;

    pom_pulse_output_mode u_pom_pulse_output_mode (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_power(phase_power),
        .pulse_output_one(pulse_output_one), .pulse_output_two(pulse_output_two),
        .pulse_output_three(pulse_output_three), .energy_capture_strobe(energy_capture_strobe)
    );
    pom_led_model u_led1 (.pin_n(pulse_output_one), .flashes(fl[0]));
    pom_led_model u_led2 (.pin_n(pulse_output_two), .flashes(fl[1]));
    pom_led_model u_led3 (.pin_n(pulse_output_three), .flashes(fl[2]));

    always #2 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task complete_run();
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask

    task set_power(input logic [2:0] src, input int ph);
        pom_pkg::pom_phase_power_type p;
        p = '0;
        case (src)
            3'h1: p.total_reactive[ph] = 16'h4000;
            3'h2: p.apparent[ph] = 16'h4000;
            3'h3: p.fund_active[ph] = 16'h4000;
            3'h4: p.fund_reactive[ph] = 16'h4000;
            default: p.total_active[ph] = 16'h4000;
        endcase
        @(posedge ref_clk);
        phase_power <= p;
    endtask

    task run_count(input int n);
        cnt = '{0, 0, 0};
        repeat (n) begin
            @(negedge ref_clk);
            for (int i = 0; i < 3; i++) begin
                cnt[i] += int'(energy_capture_strobe[i] === 1'b1);
            end
        end
    endtask

    // One pulse every four cycles, allowing for pipeline latency
    function automatic logic [31:0] rate(input int s, input logic want);
        return want ? {31'h0, s >= 14 && s <= 16} : s;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_defaults();
        rd_chk("mode reset", `POM_MODE_ADDR, 32'h0e88);
        rd_chk("unmapped read", 32'h0000_e700, 32'h0);
        check("response", {31'h0, hresp}, 32'h0);
        wr(`POM_MODE_ADDR, 32'h0000_ffff);
        rd_chk("mode top bit", `POM_MODE_ADDR, 32'h7fff);
    endtask

    task t_sources();
        logic [15:0] m;
        for (int o = 0; o < 3; o++) begin
            for (int c = 0; c < 8; c++) begin
                m = 16'h71ff;
                m[3*o +: 3] = c[2:0];
                wr(`POM_MODE_ADDR, 32'h71ff);
                set_power(c[2:0], 0);
                wr(`POM_MODE_ADDR, {16'h0, m});
                run_count(64);
                check("source rate", rate(cnt[o], c < 5), {31'h0, c < 5});
                check("other outputs", cnt[(o+1)%3] + cnt[(o+2)%3], 0);
                if (c < 5) begin
                    set_power((c == 4) ? 3'h0 : c[2:0] + 3'h1, 0);
                    run_count(8);
                    run_count(48);
                    check("wrong quantity", cnt[o], 0);
                end
            end
        end
    endtask

    task t_include();
        wr(`POM_INCLUDE_ADDR, 32'h0000_0002);
        wr(`POM_MODE_ADDR, 32'h0000_71f8);
        set_power(3'h0, 0);
        run_count(8);
        run_count(48);
        check("excluded phase", cnt[0], 0);
        set_power(3'h0, 1);
        run_count(64);
        check("included phase", rate(cnt[0], 1'b1), 32'h1);
        wr(`POM_INCLUDE_ADDR, 32'h0000_01ff);
    endtask

    task t_disable();
        int f[3];
        wr(`POM_MODE_ADDR, 32'h0000_7e00);
        set_power(3'h0, 0);
        f = fl;
        run_count(64);
        for (int i = 0; i < 3; i++) begin
            check("converter runs", rate(cnt[i], 1'b1), 32'h1);
            check("pin held high", fl[i] - f[i], 0);
        end
        wr(`POM_MODE_ADDR, 32'h0000_7000);
        run_count(16);
        for (int i = 0; i < 3; i++) begin
            check("pin enabled", fl[i] - f[i], 1);
        end
    endtask

    task t_capture();
        wr(`POM_MODE_ADDR, 32'h0000_0000);
        run_count(8);
        run_count(64);
        check("no capture", cnt[0] + cnt[1] + cnt[2], 0);
        wr(`POM_MODE_ADDR, 32'h0000_2000);
        run_count(8);
        run_count(64);
        check("capture two", rate(cnt[1], 1'b1), 32'h1);
        check("capture others", cnt[0] + cnt[2], 0);
        rd_chk("status", `POM_STATUS_ADDR, 32'h0000_0707);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        phase_power = '0;
        err_total = 0;
        checks = 0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_defaults();
        t_sources();
        t_include();
        t_disable();
        t_capture();
        complete_run();
    end
endmodule
